// ### design/hst_master.sv
`timescale 1ns/1ps
// two-wire bus master that reads and configures the converter
module hst_master
	import hst_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// bus pins, enables low while pulling
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n_o
);
	hst_pin_if pins ();

	// filtered line levels
	hst_pin_sync u_sync (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.pins      (pins)
	);
	assign pins.scl_raw = scl_i;
	assign pins.sda_raw = sda_i;

	// software-visible registers
	logic [6:0]    ctrl_r;      // last command word
	logic [6:0]    addr_r;      // target address
	logic [7:0]    txbyte_r;    // channel byte to send
	logic          go_r;        // one-cycle launch request
	logic          wait_r;      // waitrequest flop
	logic [31:0]   rdata_r;     // read data flop
	// engine
	hst_state_type state_r;     // engine state
	hst_unit_type  unit_r;      // unit in flight
	logic [1:0]    phase_r;     // quarter within a bit
	logic [3:0]    bitcnt_r;    // bit within a unit, 8 is the ack slot
	logic [7:0]    shift_r;     // shift register both ways
	logic [1:0]    rxk_r;       // bytes read so far
	logic [23:0]   result_r;    // captured result word
	logic          rd_phase_r;  // current address phase is a read
	logic          busy_r;
	logic          anak_r;      // address refused
	logic          dnak_r;      // channel byte refused
	logic          done_r;
	logic          refu_r;      // command refused locally
	logic          bbusy_r;     // bus busy seen on the lines
	logic          scl_oe_n_r;
	logic          sda_oe_n_r;
	logic          sda_o_r;
	logic          scl_o_r;
	// divider
	logic [QCNT_W-1:0] qcnt_r;
	logic              qtr_tick;
	logic              adv;
	logic              scl_d_r;     // previous agreed clock
	logic              sda_d_r;     // previous agreed data
	logic [1:0]        rd_cnt;      // bytes to read this command
	logic              last_rx;
	logic [10:0]       rsr_cnt_r;   // cycles spent in a repeated start
	// one quarter of slack over an unstretched standard-speed repeated start
	localparam logic [10:0] RSR_LIMIT = 11'(5 * QTR_STD);

	////////////////////////////////////////////////////////////////
	// register read decode, reused by the read path
	function automatic logic [31:0] reg_read(input logic [4:0] ofs);
		logic [31:0] v;
		v = 32'h0;
		case (ofs)
			OFS_CTRL:   v = {25'h0, ctrl_r};
			OFS_ADDR:   v = {25'h0, addr_r};
			OFS_TXBYTE: v = {24'h0, txbyte_r};
			OFS_STATUS: v = {26'h0, bbusy_r, refu_r, dnak_r, done_r, anak_r, busy_r};
			OFS_RESULT: v = {8'h0, result_r};
			// sign and range bits above, value below
			OFS_FIELDS: v = {14'h0, result_r[RES_SIGN], result_r[RES_MSB],
				result_r[RES_VAL_H:RES_VAL_L]};
			default:    v = 32'h0; // unmapped reads as zero
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////
	// avalon slave: every access answers at its second edge
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0;
		end else if ((avs_read_i || avs_write_i) && wait_r) begin
			// first edge: latch read data, drop waitrequest
			wait_r  <= 1'b0;
			rdata_r <= reg_read(avs_address_i);
		end else begin
			wait_r <= 1'b1;
		end
	end

	// register writes take effect where waitrequest is low
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_r   <= 7'h0;
			addr_r   <= ADDR_RST;
			txbyte_r <= TXBYTE_RST;
			go_r     <= 1'b0;
		end else begin
			go_r <= 1'b0;
			if (avs_write_i && !wait_r) begin
				case (avs_address_i)
					OFS_CTRL: begin
						// control settings are frozen while a command runs
						if (!busy_r) begin
							ctrl_r <= avs_writedata_i[6:0];
							go_r   <= avs_writedata_i[CTRL_GO];
						end
					end
					OFS_ADDR: begin
						addr_r <= avs_writedata_i[6:0];
					end
					OFS_TXBYTE: begin
						txbyte_r <= avs_writedata_i[7:0];
					end
					default: begin
						// read-only or unmapped: ignored
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// quarter-bit divider; restarts whenever idle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || state_r == ST_IDLE) begin
			qcnt_r <= '0;
		end else if (qtr_tick) begin
			qcnt_r <= '0;
		end else begin
			qcnt_r <= qcnt_r + 1'b1;
		end
	end

	// quarter length per selected speed
	assign qtr_tick = ctrl_r[CTRL_FAST] ? (qcnt_r == QCNT_W'(QTR_FAST - 1))
		: (qcnt_r == QCNT_W'(QTR_STD - 1));
	// a released clock held low by the far side stretches the bit
	assign adv     = qtr_tick && !(phase_r == 2'h2 && scl_oe_n_r && !pins.scl_lvl);
	assign rd_cnt  = (ctrl_r[CTRL_CNT_H:CTRL_CNT_L] == 2'h0) ? RD_BYTES
		: ctrl_r[CTRL_CNT_H:CTRL_CNT_L];
	assign last_rx = (rxk_r + 2'h1) == rd_cnt;

	////////////////////////////////////////////////////////////////
	// line monitor: start and stop as seen on the wires
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			bbusy_r <= 1'b0;
		end else begin
			scl_d_r <= pins.scl_lvl;
			sda_d_r <= pins.sda_lvl;
			if (scl_d_r && pins.scl_lvl && sda_d_r && !pins.sda_lvl) begin
				bbusy_r <= 1'b1;
			end else if (scl_d_r && pins.scl_lvl && !sda_d_r && pins.sda_lvl) begin
				bbusy_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// transfer engine
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_r    <= ST_IDLE;
			unit_r     <= U_ADDR;
			phase_r    <= 2'h0;
			bitcnt_r   <= 4'h0;
			shift_r    <= 8'h0;
			rxk_r      <= 2'h0;
			result_r   <= 24'h0;
			rd_phase_r <= 1'b0;
			busy_r     <= 1'b0;
			anak_r     <= 1'b0;
			dnak_r     <= 1'b0;
			done_r     <= 1'b0;
			refu_r     <= 1'b0;
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (go_r) begin
						anak_r <= 1'b0;
						dnak_r <= 1'b0;
						done_r <= 1'b0;
						refu_r <= 1'b0;
						// a plain read from the global address is never answered
						if (bbusy_r || (ctrl_r[CTRL_READ] && !ctrl_r[CTRL_RSTRT]
							&& addr_r == GLOBAL_ADDR)) begin
							refu_r <= 1'b1;
							done_r <= 1'b1;
						end else begin
							busy_r     <= 1'b1;
							state_r    <= ST_START;
							phase_r    <= 2'h0;
							rxk_r      <= 2'h0;
							rd_phase_r <= ctrl_r[CTRL_READ] && !ctrl_r[CTRL_RSTRT];
						end
					end
				end
				ST_START, ST_RSTART: begin
					if (adv) begin
						phase_r <= phase_r + 2'h1;
						case (phase_r)
							2'h0: sda_oe_n_r <= 1'b1;
							2'h1: begin
								if (state_r == ST_START) begin
									sda_oe_n_r <= 1'b0;
								end else begin
									scl_oe_n_r <= 1'b1;
								end
							end
							2'h2: begin
								if (state_r == ST_START) begin
									scl_oe_n_r <= 1'b0;
								end else begin
									sda_oe_n_r <= 1'b0;
								end
							end
							default: begin
								// address byte with direction in bit 0
								scl_oe_n_r <= 1'b0;
								state_r    <= ST_XFER;
								unit_r     <= U_ADDR;
								bitcnt_r   <= 4'h0;
								shift_r    <= {addr_r, rd_phase_r};
							end
						endcase
					end
				end
				ST_XFER: begin
					if (adv) begin
						phase_r <= phase_r + 2'h1;
						case (phase_r)
							2'h0: begin
								// clock is low here, so data may move
								if (bitcnt_r == 4'h8) begin
									sda_oe_n_r <= (unit_r == U_RX) ? last_rx : 1'b1;
								end else begin
									sda_oe_n_r <= (unit_r == U_RX) ? 1'b1 : shift_r[7];
								end
							end
							2'h1: scl_oe_n_r <= 1'b1;
							2'h2: begin
								// sample with the clock high
								if (bitcnt_r == 4'h8) begin
									if (unit_r == U_ADDR) begin
										anak_r <= pins.sda_lvl;
									end else if (unit_r == U_TX) begin
										dnak_r <= pins.sda_lvl;
									end
								end else begin
									shift_r <= {shift_r[6:0], pins.sda_lvl};
								end
							end
							default: begin
								scl_oe_n_r <= 1'b0;
								if (bitcnt_r != 4'h8) begin
									bitcnt_r <= bitcnt_r + 4'h1;
								end else begin
									bitcnt_r <= 4'h0;
									case (unit_r)
										U_ADDR: begin
											if (anak_r) begin
												state_r <= ST_STOP;
											end else if (rd_phase_r) begin
												unit_r <= U_RX;
											end else if (ctrl_r[CTRL_WBYTE]) begin
												unit_r  <= U_TX;
												shift_r <= txbyte_r;
											end else if (ctrl_r[CTRL_RSTRT]) begin
												state_r    <= ST_RSTART;
												rd_phase_r <= 1'b1;
											end else begin
												state_r <= ST_STOP;
											end
										end
										U_TX: begin
											if (!dnak_r && ctrl_r[CTRL_RSTRT]) begin
												state_r    <= ST_RSTART;
												rd_phase_r <= 1'b1;
											end else begin
												state_r <= ST_STOP;
											end
										end
										default: begin
											// most significant byte arrives first
											result_r <= {result_r[15:0], shift_r};
											rxk_r    <= rxk_r + 2'h1;
											if (last_rx) begin
												state_r <= ST_STOP;
											end
										end
									endcase
								end
							end
						endcase
					end
				end
				ST_STOP: begin
					if (adv) begin
						phase_r <= phase_r + 2'h1;
						case (phase_r)
							2'h0: sda_oe_n_r <= 1'b0;
							2'h1: scl_oe_n_r <= 1'b1;
							2'h2: sda_oe_n_r <= 1'b1;
							default: begin
								state_r <= ST_IDLE;
								busy_r  <= 1'b0;
								done_r  <= 1'b1;
							end
						endcase
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// open-drain: the output level is always low
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_o_r <= 1'b0;
			sda_o_r <= 1'b0;
		end else begin
			scl_o_r <= 1'b0;
			sda_o_r <= 1'b0;
		end
	end

	assign avs_readdata_o    = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign scl_o             = scl_o_r;
	assign scl_oe_n_o        = scl_oe_n_r;
	assign sda_o             = sda_o_r;
	assign sda_oe_n_o        = sda_oe_n_r;

	////////////////////////////////////////////////////////////////
	// checks
	a_start_shape: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		($fell(sda_oe_n_r) && state_r == ST_START) |-> scl_oe_n_r)
		else $error("start fell while clock was low");
	a_stop_shape: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		($rose(sda_oe_n_r) && state_r == ST_STOP) |-> scl_oe_n_r ##1 state_r == ST_STOP)
		else $error("stop rose while clock was low");
	a_data_clk_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		($changed(sda_oe_n_r) && state_r == ST_XFER && $past(state_r) == ST_XFER)
		|-> (!scl_oe_n_r && !$past(scl_oe_n_r)))
		else $error("data moved with clock released");
	a_unit_nine: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_r == ST_XFER && bitcnt_r == 4'h8 && unit_r != U_RX && phase_r != 2'h0)
		|-> sda_oe_n_r)
		else $error("master held data in the ack slot");
	a_rx_ack: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_r == ST_XFER && bitcnt_r == 4'h8 && unit_r == U_RX && phase_r == 2'h2)
		|-> (sda_oe_n_r == last_rx))
		else $error("wrong acknowledge on received byte");
	a_addr_dir: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		($past(state_r) != ST_XFER && state_r == ST_XFER)
		|-> (shift_r == {addr_r, rd_phase_r} && bitcnt_r == 4'h0))
		else $error("address byte badly formed");
	a_rd_limit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_r == ST_XFER && unit_r == U_RX) |-> (rxk_r < rd_cnt))
		else $error("read ran past its byte count");
	// helper count, so that the length bound needs no long delay range
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || state_r != ST_RSTART) begin
			rsr_cnt_r <= 11'h000;
		end else if (rsr_cnt_r != RSR_LIMIT) begin
			rsr_cnt_r <= rsr_cnt_r + 11'h001;
		end
	end
	a_rsr_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_r == ST_RSTART) |-> rd_phase_r)
		else $error("repeated start did not lead to a read");
	a_rsr_length: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_r == ST_RSTART) |-> (rsr_cnt_r < RSR_LIMIT))
		else $error("repeated start took too long");
	a_quarter_len: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_r != ST_IDLE) |-> (qcnt_r < QCNT_W'(QTR_STD)))
		else $error("quarter counter overran");
	a_drive_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!sda_o_r && !scl_o_r)
		else $error("line driven high");
endmodule

// ### design/hst_pin_if.sv
`timescale 1ns/1ps
// raw and filtered bus line levels
interface hst_pin_if;
	logic scl_raw;   // clock line as found on the pin
	logic sda_raw;   // data line as found on the pin
	logic scl_lvl;   // agreed clock level
	logic sda_lvl;   // agreed data level
	modport filt (input scl_raw, input sda_raw, output scl_lvl, output sda_lvl);
	modport ctl  (output scl_raw, output sda_raw, input scl_lvl, input sda_lvl);
endinterface

// ### design/hst_pin_sync.sv
`timescale 1ns/1ps
// three-flop sampler; a level counts once the last two flops agree
module hst_pin_sync (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	// lines
	hst_pin_if.filt   pins
);
	logic [2:0] scl_sh_r;   // clock line sampler chain
	logic [2:0] sda_sh_r;   // data line sampler chain
	logic       scl_r;      // agreed clock
	logic       sda_r;      // agreed data

	////////////////////////////////////////////////////////////////
	// sampler chains; idle lines read high
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_sh_r <= 3'h7;
			sda_sh_r <= 3'h7;
		end else begin
			scl_sh_r <= {scl_sh_r[1:0], pins.scl_raw};
			sda_sh_r <= {sda_sh_r[1:0], pins.sda_raw};
		end
	end

	// only the second and third flops are compared
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			if (scl_sh_r[1] == scl_sh_r[2]) begin
				scl_r <= scl_sh_r[2];
			end
			if (sda_sh_r[1] == sda_sh_r[2]) begin
				sda_r <= sda_sh_r[2];
			end
		end
	end

	assign pins.scl_lvl = scl_r;
	assign pins.sda_lvl = sda_r;
endmodule

// ### design/hst_pkg.sv
// What this block does
// - bit rate at most 100k or 400k
// - data fall, clock high: start, busy
// - data rise, clock high: stop, free
// - master makes every start and stop
// - repeated start acts as start
// - nine-bit units, transmitter releases ninth
// - acknowledge pulls low, refusal releases
// - data changes only while clock low
// - first byte: address plus direction bit
// - read up to three bytes
package hst_pkg;
	// system clock
	localparam int CLK_PERIOD_NS = 10;
	// bit periods of the two speeds, in ns
	localparam int BIT_NS_STD    = 10000;
	localparam int BIT_NS_FAST   = 2500;
	// quarter-bit counts; least time, so round up
	localparam int QTR_STD  = (BIT_NS_STD + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
	localparam int QTR_FAST = (BIT_NS_FAST + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
	localparam int QCNT_W   = 8;

	// register byte offsets
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_ADDR   = 5'h04;
	localparam logic [4:0] OFS_TXBYTE = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_RESULT = 5'h10;
	localparam logic [4:0] OFS_FIELDS = 5'h14;

	// control fields
	localparam int CTRL_GO    = 0;
	localparam int CTRL_READ  = 1;
	localparam int CTRL_WBYTE = 2;
	localparam int CTRL_RSTRT = 3;
	localparam int CTRL_FAST  = 4;
	localparam int CTRL_CNT_L = 5;
	localparam int CTRL_CNT_H = 6;

	// status fields
	localparam int STS_BUSY  = 0;
	localparam int STS_ANAK  = 1;
	localparam int STS_DONE  = 2;
	localparam int STS_DNAK  = 3;
	localparam int STS_REFU  = 4;
	localparam int STS_BBUSY = 5;

	// result layout
	localparam int RES_SIGN  = 23;
	localparam int RES_MSB   = 22;
	localparam int RES_VAL_H = 21;
	localparam int RES_VAL_L = 6;

	// reset values, global address and default read count
	localparam logic [6:0]  ADDR_RST   = 7'h14;
	localparam logic [7:0]  TXBYTE_RST = 8'hA0;
	localparam logic [6:0]  GLOBAL_ADDR = 7'h77;
	localparam logic [1:0]  RD_BYTES   = 2'h3;

	// engine states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_START  = 3'b001,
		ST_XFER   = 3'b010,
		ST_RSTART = 3'b011,
		ST_STOP   = 3'b100
	} hst_state_type;

	// kind of nine-bit unit in flight
	typedef enum logic [1:0] {
		U_ADDR = 2'b00,
		U_TX   = 2'b01,
		U_RX   = 2'b10
	} hst_unit_type;
endpackage

// ### testbench/hst_master_test.sv
`timescale 1ns/1ps
// register-level bench for the bus master
module hst_master_test;
	import hst_pkg::*;
	logic        ref_clk, reset, rd, wr;
	logic [4:0]  addr;
	logic [31:0] wdata, rdata, q;
	logic        waitreq, scl_o, scl_oe_n, sda_o, sda_oe_n, pull, cbusy;
	logic [23:0] res_in;
	logic [4:0]  chan;
	logic [7:0]  cnt, c;
	// open drain with pull-up; a driven high level would leave the line high
	wire  logic  scl = (scl_oe_n === 1'b0 && scl_o === 1'b0) ? 1'b0 : 1'b1;
	wire  logic  sda = ((sda_oe_n === 1'b0 && sda_o === 1'b0) || pull) ? 1'b0 : 1'b1;
	int          err_count = 0;
	int          check_count = 0;
	logic [23:0] tbl [4] = '{24'hA53CC0, 24'hC00000, 24'h7FFFC0, 24'h3FFFC0};
	hst_master i_dut (.ref_clk_i(ref_clk), .reset_i(reset), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
	hst_slave_model i_dev (.ref_clk_i(ref_clk), .scl_i(scl), .sda_i(sda), .result_i(res_in),
		.sda_pull_o(pull), .conv_busy_o(cbusy), .channel_o(chan), .conv_cnt_o(cnt));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		addr  <= a;
		rd    <= !w;
		wr    <= w;
		wdata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			err_count++;
			summarize();
		end
	endtask
	// start a command, poll until done, compare status flags
	task automatic run(input logic [31:0] ctrl, input logic [31:0] sts);
		int n;
		n = 0;
		c = cnt;
		bus(OFS_CTRL, 1'b1, ctrl);
		do begin
			bus(OFS_STATUS, 1'b0, 32'h0);
			n++;
		end while (q[STS_DONE] !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			err_count++;
			summarize();
		end
		chk(q & 32'h1F, sts);
	endtask
	task automatic wait_conv;
		int n;
		n = 0;
		while (cbusy !== 1'b0 && n < 10000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 10000) begin
			err_count++;
			summarize();
		end
	endtask
	initial begin
		reset = 1'b1;
		{rd, wr, addr, wdata} = '0;
		res_in = tbl[0];
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		bus(OFS_ADDR, 1'b0, 32'h0);
		chk(q, 32'h14);
		bus(OFS_TXBYTE, 1'b0, 32'h0);
		chk(q, 32'hA0);
		bus(5'h18, 1'b0, 32'h0);
		chk(q, 32'h0);
		$display("test registers done");
		run(32'h13, 32'h06);
		$display("test busy refusal done");
		// each range code, read whole; a full read restarts conversion
		for (int i = 0; i < 4; i++) begin
			wait_conv();
			run(32'h13, 32'h04);
			res_in = tbl[(i + 1) % 4];
			chk({24'h0, cnt}, {24'h0, c + 8'h01});
			bus(OFS_RESULT, 1'b0, 32'h0);
			chk(q, {8'h0, tbl[i]});
			bus(OFS_FIELDS, 1'b0, 32'h0);
			chk(q, {14'h0, tbl[i][23:6]});
		end
		$display("test range codes done");
		wait_conv();
		run(32'h23, 32'h04);
		chk({24'h0, cnt}, {24'h0, c + 8'h01});
		bus(OFS_RESULT, 1'b0, 32'h0);
		chk(q & 32'h0000FF, 32'h0000A5);
		$display("test short read done");
		wait_conv();
		bus(OFS_TXBYTE, 1'b1, 32'hBD);
		run(32'h15, 32'h04);
		chk({27'h0, chan}, 32'h1D);
		wait_conv();
		bus(OFS_TXBYTE, 1'b1, 32'h9F);
		run(32'h15, 32'h04);
		chk({27'h0, chan}, 32'h1D);
		$display("test channel write done");
		wait_conv();
		bus(OFS_ADDR, 1'b1, 32'h15);
		run(32'h13, 32'h06);
		chk({24'h0, cnt}, {24'h0, c});
		bus(OFS_ADDR, 1'b1, 32'h77);
		run(32'h11, 32'h04);
		chk({24'h0, cnt}, {24'h0, c + 8'h01});
		run(32'h13, 32'h14);
		$display("test addressing done");
		wait_conv();
		bus(OFS_ADDR, 1'b1, 32'h14);
		bus(OFS_TXBYTE, 1'b1, 32'hA0);
		run(32'h1D, 32'h04);
		chk({24'h0, cnt}, {24'h0, c + 8'h01});
		chk({27'h0, chan}, 32'h00);
		bus(OFS_RESULT, 1'b0, 32'h0);
		chk(q, {8'h0, tbl[0]});
		$display("test write then read done");
		summarize();
	end
endmodule

// ### testbench/hst_slave_model.sv
`timescale 1ns/1ps
// behavioural converter slave on the two-wire bus
module hst_slave_model
	import hst_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h14,   // pin-selected address
	parameter int         CONV_CYC = 2600     // conversion length in clocks
) (
	// clock and lines
	input  wire logic        ref_clk_i,
	input  wire logic        scl_i,        // clock is only ever sensed
	input  wire logic        sda_i,
	// converter core side
	input  wire logic [23:0] result_i,
	// data pull (1 = pull low), state seen by the bench
	output logic             sda_pull_o,   // data line both read and pulled
	output logic             conv_busy_o,
	output logic [4:0]       channel_o,
	output logic [7:0]       conv_cnt_o
);
	int         conv_left = CONV_CYC;   // power-up conversion runs first
	logic [23:0] res;                    // sign, range, value, zeros
	logic [7:0]  shreg;                  // received byte
	int         bitcnt, nbyte;
	logic       active, ph, rd, ackd, mack, pend;
	initial begin
		sda_pull_o = 1'b0;   // released: pull-up holds it high
		channel_o  = 5'h00;  // inputs 0 and 1 differential
		conv_cnt_o = 8'h00;
		active     = 1'b0;
		pend       = 1'b0;
	end
	assign conv_busy_o = (conv_left != 0);
	task automatic start_conv;
		conv_left  = CONV_CYC;
		conv_cnt_o = conv_cnt_o + 8'h01;
	endtask
	// result loads only when a conversion completes
	always @(posedge ref_clk_i) begin
		if (conv_left > 0) begin
			if (conv_left == 1)
				res = result_i;
			conv_left--;
		end
	end
	// start and repeated start restart the unit count
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			active = 1'b1;
			// the clock fall that closes the start is not a bit
			bitcnt = -1;
			ph     = 1'b0;
			sda_pull_o = 1'b0;
		end
	end
	// stop after an acked write or short read starts conversion
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			if (pend)
				start_conv();
			pend   = 1'b0;
			active = 1'b0;
			sda_pull_o = 1'b0;
		end
	end
	// bits are taken while the clock is high
	always @(posedge scl_i) begin
		if (active) begin
			if (bitcnt < 8)
				shreg = {shreg[6:0], sda_i};
			else
				mack = ~sda_i;
		end
	end
	// data-line pulls change on the falling clock; start and stop only release them
	always @(negedge scl_i) begin
		if (active && bitcnt == 8) begin
			sda_pull_o = 1'b0;
			bitcnt = 0;
			if (!ph) begin
				if (ackd) begin
					rd    = shreg[0];   // 1 read, 0 write
					nbyte = 0;
					pend  = 1'b1;
					if (rd)
						sda_pull_o = ~res[23];
				end else
					active = 1'b0;
			end else if (rd) begin
				nbyte++;
				if (nbyte == 3) begin   // full read starts conversion
					pend = 1'b0;
					start_conv();
					active = 1'b0;
				end else if (mack)
					sda_pull_o = ~res[23 - 8 * nbyte];
				else
					active = 1'b0;
			end
			ph = 1'b1;
		end else if (active) begin
			bitcnt++;
			if (bitcnt == 8) begin
				if (!ph) begin   // own or global-write address, idle core
					ackd = (shreg[7:1] == DEV_ADDR || (shreg[7:1] == GLOBAL_ADDR && !shreg[0]))
						&& !conv_busy_o;
					sda_pull_o = ackd;   // ack pulls, refusal releases
				end else if (!rd) begin
					sda_pull_o = 1'b1;
					if (shreg[7:5] == 3'b101)
						channel_o = shreg[4:0];   // leading 101 loads channel
				end else
					sda_pull_o = 1'b0;   // transmitter frees the ninth bit
			end else if (ph && rd)
				sda_pull_o = ~res[23 - 8 * nbyte - bitcnt];
		end
	end
endmodule
